// *** logic/fbk_pkg.sv ***
package fbk_pkg;

    // ------------------------------------------------------------
    // Register offsets (own map)
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CLKDIV = 4'h0;
    localparam logic [3:0] OFF_INDEX  = 4'h1;
    localparam logic [3:0] OFF_PARAM  = 4'h2;
    localparam logic [3:0] OFF_STATUS = 4'h3;
    localparam logic [3:0] OFF_SECUR  = 4'h4;
    localparam logic [3:0] OFF_PROT   = 4'h5;
    localparam logic [3:0] OFF_IRQST  = 4'h6;
    localparam logic [3:0] OFF_IRQMSK = 4'h7;

    // ------------------------------------------------------------
    // Status register bit positions
    // ------------------------------------------------------------
    localparam int ST_COMMAND_COMPLETE_FLAG   = 7;
    localparam int ST_ACCESS_ERROR_FLAG = 5;
    localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
    localparam int ST_MGERR  = 1;
    localparam int ST_MGFAT  = 0;

    // Interrupt status bits
    localparam int IR_DONE   = 0;
    localparam int IR_ACCESS_ERROR_FLAG = 1;
    localparam int IR_UNSEC  = 2;
    localparam int IR_W      = 3;

    // ------------------------------------------------------------
    // Commands, indices, encodings
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
    localparam logic [7:0] CMD_ERASE_ALL  = 8'h08;
    localparam logic [7:0] CMD_UNSECURE   = 8'h0B;
    localparam logic [7:0] CMD_KEY        = 8'h0C;
    localparam logic [2:0] IDX_CMD        = 3'h0;
    localparam logic [2:0] IDX_KEY_LAST   = 3'h4;
    localparam logic [1:0] SEC_UNSECURE   = 2'h2;
    localparam logic [1:0] SEC_SECURED    = 2'h3;
    localparam logic [1:0] BACKDOOR_ENABLE_FIELD_ON       = 2'h2;
    localparam logic [15:0] KEY_ZERO      = 16'h0000;
    localparam logic [15:0] KEY_ONES      = 16'hFFFF;
    localparam logic [17:0] KEY_BASE_ADDR = 18'h3FF00;
    localparam logic [17:0] SEC_BYTE_ADDR = 18'h3FF0F;
    localparam logic [7:0] PROT_NONE      = 8'hFF;
    localparam logic [7:0] CLKDIV_RESET   = 8'h00;
    localparam logic [7:0] SECUR_RESET    = 8'h03;
    localparam logic [7:0] STATUS_RESET   = 8'h80;

    // Busy time of any operation
    localparam int OP_TIME_NS = 200;
    localparam int CLK_NS     = 10;
    localparam int OP_CYC     = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {FBK_IDLE, FBK_BUSY, FBK_DONE} fbk_state_e;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } fbk_bus_s;

    typedef struct packed {
        logic        req;
        logic [17:0] addr;
    } fbk_rd_s;

endpackage

// *** logic/fbk_core.sv ***
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
// Behaviour
// - Erase all before divider set gives access error and no run.
// - Unknown command code sets access error, command not run.
// - Unsecure command with index not zero at launch sets access error.
// - Command not allowed in current mode sets access error.
// - Unsecure command sets protection violation if any region protected.
// - Verify errors set error flag; fatal errors set fatal flag.
// - Key command with backdoor disabled sets access error and ends.
// - Keys compared with stored words starting at 0x3_FF00 in order.
// - Key match unsecures, security state forced to 10.
// - Key mismatch keeps security, later key commands aborted until reset.
// - Complete flag set after key verify, match or not.
// - Keys 0x0000 and 0xFFFF are invalid, never release security.
// - Flash reads return invalid data while key command runs.
// - Stored security byte and key words untouched by key command.
// - Protection register untouched by key command.
// - After special-mode reset, erase-verify all; unsecure if erased.
module fbk_core (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire fbk_pkg::fbk_bus_s bus,
    output logic [15:0]           rdata,
    input  wire logic             special_mode,
    input  wire logic [63:0]      stored_keys,
    input  wire logic             flash_erased,
    input  wire logic             verify_error,
    input  wire logic             verify_fatal,
    input  wire fbk_pkg::fbk_rd_s flash_rd,
    input  wire logic [15:0]      flash_rdata,
    output logic [15:0]           rd_data,
    output logic                  rd_valid,
    output logic                  erase_start,
    output logic                  debug_enabled,
    output logic                  irq
);
    import fbk_pkg::*;

    logic [7:0]            clkdiv;
    logic                  div_set;
    logic [2:0]            index;
    logic [15:0]           param [0:4];
    logic [7:0]            status;
    logic [1:0]            sec_state;
    logic [1:0]            backdoor_enable_field;
    logic [7:0]            prot;
    logic [IR_W-1:0]       irq_st;
    logic [IR_W-1:0]       irq_msk;
    logic                  key_locked;
    fbk_state_e            state;
    logic [7:0]            cnt;
    logic [7:0]            cur_cmd;
    logic                  key_busy;
    logic                  post_reset;
    logic                  launch;
    logic                  acc_err;
    logic                  prot_err;
    logic                  key_ok;
    logic [IR_W-1:0]       irq_set;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic key_valid(input logic [15:0] k);
        key_valid = (k != KEY_ZERO) && (k != KEY_ONES);
    endfunction

    function automatic logic known_cmd(input logic [7:0] c);
        known_cmd = (c == CMD_VERIFY_ALL) || (c == CMD_ERASE_ALL) ||
                    (c == CMD_UNSECURE) || (c == CMD_KEY);
    endfunction

    function automatic logic wr_at(input fbk_bus_s b, input logic [3:0] off);
        wr_at = b.wr && (b.addr == off);
    endfunction

    // Launch: writing a one to the complete bit while idle
    assign launch = wr_at(bus, OFF_STATUS) && bus.wdata[ST_COMMAND_COMPLETE_FLAG] && (state == FBK_IDLE);

    // ------------------------------------------------------------
    // Launch checks
    // ------------------------------------------------------------
    always_comb begin
        acc_err  = 1'b0;
        prot_err = 1'b0;
        if (!known_cmd(param[0][15:8])) begin
            acc_err = 1'b1;
        end else if (!div_set && (param[0][15:8] == CMD_ERASE_ALL)) begin
            acc_err = 1'b1;
        end else if (param[0][15:8] == CMD_ERASE_ALL && !special_mode) begin
            acc_err = 1'b1;
        end else if (param[0][15:8] == CMD_UNSECURE) begin
            acc_err  = (index != IDX_CMD) || !special_mode;
            prot_err = (prot != PROT_NONE);
        end else if (param[0][15:8] == CMD_KEY) begin
            acc_err = (backdoor_enable_field != BACKDOOR_ENABLE_FIELD_ON) || key_locked ||
                      (index != IDX_KEY_LAST);
        end
    end

    // Keys compared word by word from the lowest stored address upward
    always_comb begin
        key_ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (param[i+1] != stored_keys[16*i +: 16] || !key_valid(param[i+1])) begin
                key_ok = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state   <= FBK_IDLE;
            cnt     <= 8'h00;
            cur_cmd <= 8'h00;
        end else begin
            case (state)
                FBK_IDLE: begin
                    if (launch && !acc_err && !prot_err) begin
                        state   <= FBK_BUSY;
                        cur_cmd <= param[0][15:8];
                        cnt     <= 8'(OP_CYC);
                    end else if (post_reset) begin
                        state   <= FBK_BUSY;
                        cur_cmd <= CMD_VERIFY_ALL;
                        cnt     <= 8'(OP_CYC);
                    end
                end
                FBK_BUSY: begin
                    if (cnt == 8'h01) begin
                        state <= FBK_DONE;
                    end
                    cnt <= cnt - 8'h01;
                end
                default: begin
                    state <= FBK_IDLE;
                end
            endcase
        end
    end

    assign key_busy = (state != FBK_IDLE) && (cur_cmd == CMD_KEY);

    // Self-started verify after every reset, in either mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            post_reset <= 1'b1;
        end else begin
            post_reset <= 1'b0;
        end
    end

    assign erase_start = (state == FBK_BUSY) && (cnt == 8'(OP_CYC)) && (cur_cmd == CMD_ERASE_ALL);

    // ------------------------------------------------------------
    // Status and security state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status <= STATUS_RESET;
        end else begin
            if (launch) begin
                status[ST_COMMAND_COMPLETE_FLAG]   <= acc_err || prot_err;
                status[ST_ACCESS_ERROR_FLAG] <= acc_err;
                status[ST_PROTECTION_VIOLATION_FLAG] <= prot_err;
                status[ST_MGERR]  <= 1'b0;
                status[ST_MGFAT]  <= 1'b0;
            end else if (post_reset && state == FBK_IDLE) begin
                status[ST_COMMAND_COMPLETE_FLAG] <= 1'b0;
            end else if (state == FBK_DONE) begin
                status[ST_COMMAND_COMPLETE_FLAG] <= 1'b1;
                if (cur_cmd == CMD_UNSECURE || cur_cmd == CMD_VERIFY_ALL) begin
                    status[ST_MGERR] <= verify_error;
                    status[ST_MGFAT] <= verify_fatal;
                end
            end
        end
    end

    // Only the volatile state moves; stored bytes and protection stay put
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sec_state     <= SEC_SECURED;
            backdoor_enable_field         <= 2'h0;
            key_locked    <= 1'b0;
            debug_enabled <= 1'b0;
        end else begin
            if (wr_at(bus, OFF_SECUR)) begin
                backdoor_enable_field <= bus.wdata[7:6];
            end
            if (state == FBK_DONE && cur_cmd == CMD_KEY) begin
                if (key_ok) begin
                    sec_state <= SEC_UNSECURE;
                end else begin
                    key_locked <= 1'b1;
                end
            end
            if (state == FBK_DONE && cur_cmd == CMD_VERIFY_ALL && special_mode && flash_erased) begin
                sec_state     <= SEC_UNSECURE;
                debug_enabled <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clkdiv  <= CLKDIV_RESET;
            div_set <= 1'b0;
            index   <= 3'h0;
            prot    <= PROT_NONE;
            irq_msk <= '0;
            for (int i = 0; i < 5; i++) begin
                param[i] <= 16'h0000;
            end
        end else begin
            if (wr_at(bus, OFF_CLKDIV)) begin
                clkdiv  <= bus.wdata[7:0];
                div_set <= 1'b1;
            end
            if (wr_at(bus, OFF_INDEX)) begin
                index <= bus.wdata[2:0];
            end
            if (wr_at(bus, OFF_PARAM) && index <= IDX_KEY_LAST && state == FBK_IDLE) begin
                param[index] <= bus.wdata;
            end
            // Locked while a key check runs
            if (wr_at(bus, OFF_PROT) && !key_busy) begin
                prot <= bus.wdata[7:0];
            end
            if (wr_at(bus, OFF_IRQMSK)) begin
                irq_msk <= bus.wdata[IR_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_comb begin
        irq_set            = '0;
        irq_set[IR_DONE]   = (state == FBK_DONE);
        irq_set[IR_ACCESS_ERROR_FLAG] = launch && acc_err;
        irq_set[IR_UNSEC]  = (state == FBK_DONE) && (cur_cmd == CMD_KEY) && key_ok;
    end

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_st <= '0;
        end else begin
            if (wr_at(bus, OFF_IRQST)) begin
                irq_st <= (irq_st & ~bus.wdata[IR_W-1:0]) | irq_set;
            end else begin
                irq_st <= irq_st | irq_set;
            end
        end
    end

    assign irq = |(irq_st & irq_msk);

    // ------------------------------------------------------------
    // Read paths
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            if (bus.addr == OFF_CLKDIV) begin
                rdata <= {8'h00, clkdiv};
            end else if (bus.addr == OFF_INDEX) begin
                rdata <= {13'h0000, index};
            end else if (bus.addr == OFF_PARAM) begin
                rdata <= (index <= IDX_KEY_LAST) ? param[index] : 16'h0000;
            end else if (bus.addr == OFF_STATUS) begin
                rdata <= {8'h00, status};
            end else if (bus.addr == OFF_SECUR) begin
                rdata <= {8'h00, backdoor_enable_field, 4'h0, sec_state};
            end else if (bus.addr == OFF_PROT) begin
                rdata <= {8'h00, prot};
            end else if (bus.addr == OFF_IRQST) begin
                rdata <= {13'h0000, irq_st};
            end else if (bus.addr == OFF_IRQMSK) begin
                rdata <= {13'h0000, irq_msk};
            end else begin
                rdata <= 16'h0000;
            end
        end else begin
            rdata <= 16'h0000;
        end
    end

    // Reads during a key check give all ones, not array contents
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= flash_rd.req;
            if (flash_rd.req) begin
                rd_data <= key_busy ? KEY_ONES : flash_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    unknown_cmd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        launch && !known_cmd(param[0][15:8]) |=> status[ST_ACCESS_ERROR_FLAG] && state == FBK_IDLE)
        else $error("unknown command not refused");

    div_unset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        launch && !div_set && param[0][15:8] == CMD_ERASE_ALL |=> status[ST_ACCESS_ERROR_FLAG])
        else $error("erase ran before divider set");

    unsec_index_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        launch && param[0][15:8] == CMD_UNSECURE && index != IDX_CMD |=> status[ST_ACCESS_ERROR_FLAG])
        else $error("unsecure index not checked");

    mode_check_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        launch && param[0][15:8] == CMD_ERASE_ALL && !special_mode |=> status[ST_ACCESS_ERROR_FLAG])
        else $error("command ran in wrong mode");

    prot_viol_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        launch && param[0][15:8] == CMD_UNSECURE && prot != PROT_NONE |=> status[ST_PROTECTION_VIOLATION_FLAG])
        else $error("protection violation missed");

    verify_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == FBK_DONE && cur_cmd == CMD_UNSECURE |=> status[ST_MGERR] == $past(verify_error))
        else $error("verify error flag wrong");

    key_disabled_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        launch && param[0][15:8] == CMD_KEY && backdoor_enable_field != BACKDOOR_ENABLE_FIELD_ON |=> status[ST_ACCESS_ERROR_FLAG] && state == FBK_IDLE)
        else $error("disabled key command ran");

    key_unsec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == FBK_DONE && cur_cmd == CMD_KEY && key_ok |=> sec_state == SEC_UNSECURE)
        else $error("key match did not unsecure");

    key_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        key_locked && launch && param[0][15:8] == CMD_KEY |=> status[ST_ACCESS_ERROR_FLAG])
        else $error("locked key command not aborted");

    key_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == FBK_BUSY && cur_cmd == CMD_KEY && cnt == 8'h01 |=> ##1 status[ST_COMMAND_COMPLETE_FLAG])
        else $error("complete flag not set");

    bad_key_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !key_valid(param[1]) |-> !key_ok)
        else $error("invalid key accepted");

    read_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flash_rd.req && key_busy |=> rd_data == KEY_ONES)
        else $error("read passed during key check");

    prot_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        key_busy |=> prot == $past(prot))
        else $error("protection changed by key command");

endmodule

// *** tb/fbk_flash_model.sv ***
`timescale 1ns/1ns
module fbk_flash_model (
    input  wire logic             clk_sys,
    input  wire fbk_pkg::fbk_rd_s flash_rd,
    input  wire logic             weak_key,
    input  wire logic             erased,
    output logic [63:0]           stored_keys,
    output logic                  flash_erased,
    output logic [15:0]           flash_rdata
);
    import fbk_pkg::*;
    logic [15:0] noise = 16'h0001;

    // ------------------------------------------------------------
    // Array contents
    // ------------------------------------------------------------
    // Keys are fixed words except the top one, 0xFFFF when weak_key is set; the device has no path to rewrite them
    assign stored_keys  = {weak_key ? KEY_ONES : 16'h4444, 16'h3333, 16'h2222, 16'h1111};
    assign flash_erased = erased;

    // Off-request data churns so that a stale sample cannot pass
    always_ff @(posedge clk_sys) begin
        noise <= noise + 16'h3C3D;
    end
    assign flash_rdata = flash_rd.req ? 16'h5A5A : noise;
endmodule

// *** tb/tb_flash_backdoor_key_security.sv ***
`timescale 1ns/1ns
module tb_flash_backdoor_key_security;
    import fbk_pkg::*;
    localparam logic [63:0] KEYS = 64'h4444_3333_2222_1111;
    logic clk_sys, rst_n, special_mode, erased, weak_key, verify_error, verify_fatal;
    logic rd_valid, erase_start, debug_enabled, irq, flash_erased;
    logic [15:0] rdata, rd_data, flash_rdata;
    logic [63:0] stored_keys;
    fbk_bus_s bus;
    fbk_rd_s  fr;
    int num_errors, total_checks;

    fbk_core i_fbk_core (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .special_mode(special_mode), .stored_keys(stored_keys), .flash_erased(flash_erased),
        .verify_error(verify_error), .verify_fatal(verify_fatal), .flash_rd(fr),
        .flash_rdata(flash_rdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .erase_start(erase_start), .debug_enabled(debug_enabled), .irq(irq));
    fbk_flash_model i_fbk_flash_model (.clk_sys(clk_sys), .flash_rd(fr), .weak_key(weak_key),
        .erased(erased), .stored_keys(stored_keys), .flash_erased(flash_erased),
        .flash_rdata(flash_rdata));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic expect_reg(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        check(v, e);
    endtask
    // Bounded poll; a hang shows up as a wrong status afterwards
    task automatic wait_done;
        logic [15:0] v;
        v = '0;
        for (int i = 0; i < 100 && v[ST_COMMAND_COMPLETE_FLAG] !== 1'b1; i++) begin
            rd(OFF_STATUS, v);
        end
    endtask
    task automatic do_reset(input logic sm, input logic er);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        special_mode <= sm;
        erased <= er;
        verify_error <= 1'b0;
        verify_fatal <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_done();
    endtask
    task automatic load(input logic [7:0] code, input logic [63:0] k);
        wr(OFF_INDEX, 16'h0000);
        wr(OFF_PARAM, {code, 8'h00});
        for (int i = 1; i <= 4; i++) begin
            wr(OFF_INDEX, 16'(i));
            wr(OFF_PARAM, k[16*(i-1) +: 16]);
        end
    endtask
    task automatic fread(input logic [15:0] e);
        @(posedge clk_sys);
        fr <= '{req: 1'b1, addr: KEY_BASE_ADDR};
        @(posedge clk_sys);
        fr.req <= 1'b0;
        #1 check({15'h0000, rd_valid}, 16'h0001);
        check(rd_data, e);
    endtask
    task automatic finish_test;
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #400000;
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        bus = '0;
        fr = '0;
        {special_mode, erased, weak_key, verify_error, verify_fatal} = '0;
        do_reset(1'b0, 1'b0);
        expect_reg(OFF_STATUS, STATUS_RESET);
        expect_reg(OFF_SECUR, 16'h0003);
        expect_reg(OFF_PROT, 16'h00FF);
        check({15'h0000, debug_enabled}, 16'h0000);
        load(CMD_KEY, KEYS);
        wr(OFF_STATUS, 16'h0080);
        expect_reg(OFF_STATUS, 16'h00A0);
        expect_reg(OFF_SECUR, 16'h0003);
        do_reset(1'b0, 1'b0);
        load(8'h55, KEYS);
        wr(OFF_STATUS, 16'h0080);
        expect_reg(OFF_STATUS, 16'h00A0);
        do_reset(1'b1, 1'b0);
        load(CMD_ERASE_ALL, KEYS);
        wr(OFF_STATUS, 16'h0080);
        expect_reg(OFF_STATUS, 16'h00A0);
        do_reset(1'b1, 1'b0);
        wr(OFF_CLKDIV, 16'h0010);
        load(CMD_UNSECURE, KEYS);
        wr(OFF_STATUS, 16'h0080);
        expect_reg(OFF_STATUS, 16'h00A0);
        do_reset(1'b0, 1'b0);
        wr(OFF_CLKDIV, 16'h0010);
        load(CMD_ERASE_ALL, KEYS);
        wr(OFF_STATUS, 16'h0080);
        expect_reg(OFF_STATUS, 16'h00A0);
        do_reset(1'b1, 1'b0);
        wr(OFF_CLKDIV, 16'h0010);
        wr(OFF_PROT, 16'h007F);
        load(CMD_UNSECURE, KEYS);
        wr(OFF_INDEX, 16'h0000);
        wr(OFF_STATUS, 16'h0080);
        expect_reg(OFF_STATUS, 16'h0090);
        do_reset(1'b1, 1'b0);
        wr(OFF_CLKDIV, 16'h0010);
        load(CMD_UNSECURE, KEYS);
        wr(OFF_INDEX, 16'h0000);
        verify_error <= 1'b1;
        verify_fatal <= 1'b1;
        wr(OFF_STATUS, 16'h0080);
        wait_done();
        expect_reg(OFF_STATUS, 16'h0083);
        // Host side of the debug-port unsecure: erase all, reset again with the array erased
        do_reset(1'b1, 1'b0);
        wr(OFF_CLKDIV, 16'h0010);
        load(CMD_ERASE_ALL, KEYS);
        wr(OFF_STATUS, 16'h0080);
        #1 check({15'h0000, erase_start}, 16'h0001);
        wait_done();
        expect_reg(OFF_STATUS, 16'h0080);
        do_reset(1'b1, 1'b1);
        check({15'h0000, debug_enabled}, 16'h0001);
        expect_reg(OFF_SECUR, 16'h0002);
        do_reset(1'b0, 1'b0);
        @(posedge clk_sys);
        weak_key <= 1'b1;
        wr(OFF_SECUR, 16'h0080);
        load(CMD_KEY, {KEY_ONES, KEYS[47:0]});
        wr(OFF_STATUS, 16'h0080);
        wait_done();
        expect_reg(OFF_STATUS, 16'h0080);
        expect_reg(OFF_SECUR, 16'h0083);
        @(posedge clk_sys);
        weak_key <= 1'b0;
        load(CMD_KEY, KEYS);
        wr(OFF_STATUS, 16'h0080);
        expect_reg(OFF_STATUS, 16'h00A0);
        expect_reg(OFF_SECUR, 16'h0083);
        do_reset(1'b0, 1'b0);
        wr(OFF_IRQST, 16'h0007);
        wr(OFF_SECUR, 16'h0080);
        wr(OFF_PROT, 16'h003F);
        load(CMD_KEY, KEYS);
        wr(OFF_STATUS, 16'h0080);
        fread(16'hFFFF);
        wr(OFF_PROT, 16'h00FF);
        wait_done();
        expect_reg(OFF_STATUS, 16'h0080);
        expect_reg(OFF_SECUR, 16'h0082);
        expect_reg(OFF_PROT, 16'h003F);
        fread(16'h5A5A);
        check({15'h0000, irq}, 16'h0000);
        expect_reg(OFF_IRQST, 16'h0005);
        wr(OFF_IRQMSK, 16'h0004);
        #1 check({15'h0000, irq}, 16'h0001);
        wr(OFF_IRQST, 16'h0004);
        #1 check({15'h0000, irq}, 16'h0000);
        finish_test();
    end
endmodule
